// ==== csf_clock_ctrl.sv ====
`timescale 1ns/1ps
// How it works
// - output divider divides by even 2..2^25-2
// - config bit picks pin or register selection
// - select 00/01/10/11 = in0/in1/in2/crystal
// - loss status per input, feedback, pll
// - status readable; unlock drives low pin
// - each status has own sticky latch
// - writing zero clears sticky latch
// - interrupt pin asserts when a status bit rises
// - masked sources never assert interrupt
// - interrupt releases when no unmasked latch
// - gate pin high disables all outputs
// - enabled outputs individually disabled by register
// - disabled output holds low or high
// - disable mode sync or async, sync default
// - sync disable finishes current period first
// - async disable stops output at once
// - each output selects any synthesizer
// - single-ended pins complementary or in phase
// - crystal or clock mode; clock disables caps
// - drive strength 1, 2 or 3
// - zero delay takes external feedback
module csf_clock_ctrl
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [1:0] ref_sel_pins,
	input wire logic output_gate_pin_n,
	input wire logic [3:0] input_absent_status,
	input wire logic feedback_absent_status,
	input wire logic pll_unlocked_status,
	input wire logic [csf_pkg::N_SYN-1:0] synth_tick,
	output logic [1:0] active_ref_sel,
	output logic crystal_osc_en,
	output logic load_cap_en,
	output logic external_feedback_sel,
	output logic pll_unlocked_pin_n,
	output logic irq_pin_n,
	output logic [csf_pkg::N_OUT-1:0] clock_true_pin,
	output logic [csf_pkg::N_OUT-1:0] clock_complement_pin,
	output logic [csf_pkg::N_OUT-1:0] driver_en,
	output logic [2*csf_pkg::N_OUT-1:0] single_ended_drive_strength
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [csf_pkg::N_PIN-1:0] pin_s1_r;
	logic [csf_pkg::N_PIN-1:0] pin_s2_r;
	logic [csf_pkg::N_PIN-1:0] pin_s3_r;
	logic [csf_pkg::N_PIN-1:0] pin_f_r;
	logic [csf_pkg::N_PIN-1:0] pin_raw;
	logic [csf_pkg::N_PIN-1:0] pin_agree;
	logic [csf_pkg::N_STAT-1:0] stat;
	logic gate_n;
	logic [1:0] pin_sel_val;

	assign pin_raw = {ref_sel_pins, output_gate_pin_n, pll_unlocked_status,
		feedback_absent_status, input_absent_status};
	assign pin_agree = ~(pin_s2_r ^ pin_s3_r);
	assign stat = pin_f_r[5:0];
	assign gate_n = pin_f_r[6];
	assign pin_sel_val = pin_f_r[8:7];

	// three stages; change accepted when stages 2 and 3 agree
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_s1_r <= csf_pkg::PIN_RST;
			pin_s2_r <= csf_pkg::PIN_RST;
			pin_s3_r <= csf_pkg::PIN_RST;
			pin_f_r <= csf_pkg::PIN_RST;
		end
		else
		begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_f_r <= (pin_agree & pin_s3_r) | (~pin_agree & pin_f_r);
		end
	end

	// ----------------------------------------------------------------
	// ahb-lite slave
	// ----------------------------------------------------------------
	logic [4:0] ctrl_r;
	logic [csf_pkg::N_STAT-1:0] sticky_latch_r;
	logic [csf_pkg::N_STAT-1:0] stat_d_r;
	logic [csf_pkg::N_STAT-1:0] mask_r;
	logic [csf_pkg::N_OUT-1:0] out_en_r;
	logic [8*csf_pkg::N_OUT-1:0] out_cfg_r;
	logic [csf_pkg::DIV_W-1:0] div_r [csf_pkg::N_OUT];
	logic [csf_pkg::N_OUT-1:0] running;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic addr_ok;
	logic [31:0] rd_nxt;

	assign addr_ok = hsel && hready && htrans[1];

	// capture write address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end
		else
		begin
			if (hready)
			begin
				wr_pend_r <= addr_ok && hwrite;
			end
			if (addr_ok)
			begin
				wr_addr_r <= haddr[7:0];
			end
		end
	end

	// read mux; unmapped reads zero
	always_comb
	begin
		rd_nxt = 32'h00000000;
		case (haddr[7:0])
			csf_pkg::OFS_CTRL: rd_nxt = {27'h0000000, ctrl_r};
			csf_pkg::OFS_STATUS: rd_nxt = {26'h0000000, stat};
			csf_pkg::OFS_STICKY: rd_nxt = {26'h0000000, sticky_latch_r};
			csf_pkg::OFS_MASK: rd_nxt = {26'h0000000, mask_r};
			csf_pkg::OFS_OUT_EN: rd_nxt = {28'h0000000, out_en_r};
			csf_pkg::OFS_OUT_CFG: rd_nxt = out_cfg_r;
			csf_pkg::OFS_ACTIVE: rd_nxt = {26'h0000000, running, active_ref_sel};
			default:
			begin
				for (int k = 0; k < csf_pkg::N_OUT; k++)
				begin
					if (haddr[7:0] == csf_pkg::OFS_DIV0 + 8'(4 * k))
					begin
						rd_nxt = {7'h00, div_r[k]};
					end
				end
			end
		endcase
	end

	// registered read data and response
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (addr_ok && !hwrite)
			begin
				hrdata <= rd_nxt;
			end
		end
	end

	// plain configuration registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_r <= csf_pkg::CTRL_RST;
			mask_r <= csf_pkg::MASK_RST;
			out_en_r <= csf_pkg::OUT_EN_RST;
			// reset leaves every output in sync disable
			out_cfg_r <= {csf_pkg::N_OUT{csf_pkg::CFG_RST}};
			for (int k = 0; k < csf_pkg::N_OUT; k++)
			begin
				div_r[k] <= csf_pkg::DIV_RST;
			end
		end
		else if (wr_pend_r)
		begin
			case (wr_addr_r)
				csf_pkg::OFS_CTRL: ctrl_r <= hwdata[4:0];
				csf_pkg::OFS_MASK: mask_r <= hwdata[5:0];
				csf_pkg::OFS_OUT_EN: out_en_r <= hwdata[3:0];
				csf_pkg::OFS_OUT_CFG:
				begin
					for (int k = 0; k < csf_pkg::N_OUT; k++)
					begin
						out_cfg_r[8*k +: 8] <= hwdata[8*k +: 8];
						if (hwdata[8*k+csf_pkg::CFG_DRV +: 2] == 2'h0)
						begin
							out_cfg_r[8*k+csf_pkg::CFG_DRV +: 2] <= csf_pkg::DRV_MIN;
						end
					end
				end
				default:
				begin
					for (int k = 0; k < csf_pkg::N_OUT; k++)
					begin
						if (wr_addr_r == csf_pkg::OFS_DIV0 + 8'(4 * k))
						begin
							div_r[k] <= (hwdata[24:1] == 24'h000000) ? csf_pkg::DIV_RST
								: {hwdata[24:1], 1'b0};
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// status latches and interrupt
	// ----------------------------------------------------------------
	logic [csf_pkg::N_STAT-1:0] stat_rise;
	logic [csf_pkg::N_STAT-1:0] clr_keep;

	assign stat_rise = stat & ~stat_d_r;
	assign clr_keep = (wr_pend_r && wr_addr_r == csf_pkg::OFS_STICKY) ? hwdata[5:0]
		: {csf_pkg::N_STAT{1'b1}};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stat_d_r <= '0;
			sticky_latch_r <= '0;
		end
		else
		begin
			stat_d_r <= stat;
			sticky_latch_r <= (sticky_latch_r & clr_keep) | stat_rise;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_pin_n <= 1'b1;
			pll_unlocked_pin_n <= 1'b1;
		end
		else
		begin
			irq_pin_n <= ~|(sticky_latch_r & ~mask_r);
			pll_unlocked_pin_n <= ~stat[5];
		end
	end

	// ----------------------------------------------------------------
	// reference selection and input modes
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			active_ref_sel <= 2'h0;
			crystal_osc_en <= 1'b1;
			load_cap_en <= 1'b1;
			external_feedback_sel <= 1'b0;
		end
		else
		begin
			active_ref_sel <= ctrl_r[csf_pkg::CTRL_PIN_SEL] ? pin_sel_val
				: ctrl_r[csf_pkg::CTRL_REG_SEL +: 2];
			crystal_osc_en <= ctrl_r[csf_pkg::CTRL_XTAL];
			load_cap_en <= ctrl_r[csf_pkg::CTRL_XTAL];
			external_feedback_sel <= ctrl_r[csf_pkg::CTRL_ZDM];
		end
	end

	// ----------------------------------------------------------------
	// output stages
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < csf_pkg::N_OUT; g++)
		begin : g_out
			csf_pkg::csf_oc_st_t st_r;
			logic [1:0] src_r;
			logic [23:0] half_r;
			logic [23:0] cnt_r;
			logic phase_r;
			logic want_on;
			logic tick;
			logic edge_now;
			logic period_end;
			logic [7:0] cfg;

			assign cfg = out_cfg_r[8*g +: 8];
			assign want_on = !gate_n && out_en_r[g];
			assign tick = synth_tick[src_r];
			assign edge_now = tick && (cnt_r == half_r - 24'h000001);
			assign period_end = edge_now && phase_r;
			assign running[g] = (st_r != csf_pkg::OC_OFF);

			// state, divider and phase
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					st_r <= csf_pkg::OC_OFF;
					src_r <= 2'h0;
					half_r <= 24'h000001;
					cnt_r <= 24'h000000;
					phase_r <= 1'b0;
				end
				else
				begin
					if (st_r != csf_pkg::OC_OFF && tick)
					begin
						cnt_r <= edge_now ? 24'h000000 : cnt_r + 24'h000001;
						phase_r <= edge_now ? ~phase_r : phase_r;
					end
					case (st_r)
						csf_pkg::OC_OFF:
						begin
							src_r <= cfg[csf_pkg::CFG_SRC +: 2];
							half_r <= div_r[g][24:1];
							cnt_r <= 24'h000000;
							phase_r <= 1'b0;
							if (want_on)
							begin
								st_r <= csf_pkg::OC_RUN;
							end
						end
						csf_pkg::OC_RUN:
						begin
							if (period_end)
							begin
								src_r <= cfg[csf_pkg::CFG_SRC +: 2];
								half_r <= div_r[g][24:1];
							end
							if (!want_on)
							begin
								if (cfg[csf_pkg::CFG_ASYNC])
								begin
									st_r <= csf_pkg::OC_OFF;
								end
								else
								begin
									st_r <= csf_pkg::OC_DRAIN;
								end
							end
						end
						csf_pkg::OC_DRAIN:
						begin
							if (period_end || cfg[csf_pkg::CFG_ASYNC])
							begin
								st_r <= csf_pkg::OC_OFF;
							end
							else if (want_on)
							begin
								st_r <= csf_pkg::OC_RUN;
							end
						end
						default: st_r <= csf_pkg::OC_OFF;
					endcase
				end
			end

			// pin drive
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					clock_true_pin[g] <= 1'b0;
					clock_complement_pin[g] <= 1'b1;
					driver_en[g] <= 1'b0;
					single_ended_drive_strength[2*g +: 2] <= 2'h3;
				end
				else
				begin
					driver_en[g] <= running[g];
					clock_true_pin[g] <= running[g] ? phase_r : cfg[csf_pkg::CFG_LVL];
					clock_complement_pin[g] <= (running[g] ? phase_r : cfg[csf_pkg::CFG_LVL])
						^ ~(cfg[csf_pkg::CFG_SE] && cfg[csf_pkg::CFG_INPH]);
					single_ended_drive_strength[2*g +: 2] <= cfg[csf_pkg::CFG_DRV +: 2];
				end
			end
		end
	endgenerate
endmodule // csf_clock_ctrl

// ==== csf_pkg.sv ====
package csf_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int N_OUT = 4;
	localparam int N_SYN = 4;
	localparam int DIV_W = 25;
	localparam int N_STAT = 6;
	localparam int N_PIN = 9;
	localparam logic [31:0] CLK_HZ = 32'h02625a00;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_STICKY = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0c;
	localparam logic [7:0] OFS_OUT_EN = 8'h10;
	localparam logic [7:0] OFS_OUT_CFG = 8'h14;
	localparam logic [7:0] OFS_ACTIVE = 8'h18;
	localparam logic [7:0] OFS_DIV0 = 8'h20;

	// ----------------------------------------------------------------
	// ctrl fields
	// ----------------------------------------------------------------
	localparam int CTRL_PIN_SEL = 0;
	localparam int CTRL_REG_SEL = 1;
	localparam int CTRL_XTAL = 3;
	localparam int CTRL_ZDM = 4;
	localparam logic [4:0] CTRL_RST = 5'h08;

	// ----------------------------------------------------------------
	// per-output cfg byte fields
	// ----------------------------------------------------------------
	localparam int CFG_SRC = 0;
	localparam int CFG_LVL = 2;
	localparam int CFG_ASYNC = 3;
	localparam int CFG_SE = 4;
	localparam int CFG_INPH = 5;
	localparam int CFG_DRV = 6;
	localparam logic [7:0] CFG_RST = 8'hc0;
	localparam logic [1:0] DRV_MIN = 2'h1;

	// ----------------------------------------------------------------
	// other reset values
	// ----------------------------------------------------------------
	localparam logic [N_STAT-1:0] MASK_RST = 6'h00;
	localparam logic [N_OUT-1:0] OUT_EN_RST = 4'hf;
	localparam logic [DIV_W-1:0] DIV_RST = 25'h0000002;
	// in_sel(2) pulled up, oe_n high, status low
	localparam logic [N_PIN-1:0] PIN_RST = 9'h1c0;

	// output stage states
	typedef enum logic [1:0] {
		OC_OFF = 2'b00,
		OC_RUN = 2'b01,
		OC_DRAIN = 2'b10
	} csf_oc_st_t;
endpackage

// ==== csf_synth_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// synthesizer tick source
// ----------------------------------------
module csf_synth_model
(
	input wire logic hclk,
	input wire logic hresetn,
	output logic [csf_pkg::N_SYN-1:0] synth_tick
);
	logic [3:0] cnt_r [csf_pkg::N_SYN];
	// synth i pulses once every i+2 cycles
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_r <= '{default: 4'h0};
			synth_tick <= '0;
		end
		else
		begin
			for (int i = 0; i < csf_pkg::N_SYN; i++)
			begin
				cnt_r[i] <= (cnt_r[i] == 4'(i + 1)) ? 4'h0 : cnt_r[i] + 4'h1;
				synth_tick[i] <= (cnt_r[i] == 4'(i + 1));
			end
		end
	end
endmodule // csf_synth_model

// ==== csf_clock_ctrl_properties.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// port-level checks
// ----------------------------------------
module csf_checker
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic output_gate_pin_n,
	input wire logic pll_unlocked_status,
	input wire logic crystal_osc_en,
	input wire logic load_cap_en,
	input wire logic pll_unlocked_pin_n,
	input wire logic irq_pin_n,
	input wire logic [csf_pkg::N_OUT-1:0] clock_true_pin,
	input wire logic [csf_pkg::N_OUT-1:0] clock_complement_pin,
	input wire logic [csf_pkg::N_OUT-1:0] driver_en,
	input wire logic [2*csf_pkg::N_OUT-1:0] single_ended_drive_strength
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic bus_wr;
	logic drv_ok;
	// bus write request and drive field sanity
	assign bus_wr = hsel & htrans[1] & hwrite;
	assign drv_ok = &{|single_ended_drive_strength[1:0], |single_ended_drive_strength[3:2],
		|single_ended_drive_strength[5:4], |single_ended_drive_strength[7:6]};
	sequence s_unlock_on;
		pll_unlocked_status[*8];
	endsequence
	sequence s_unlock_off;
		!pll_unlocked_status[*8];
	endsequence
	sequence s_idle_off;
		(!driver_en[0] && !(hsel && htrans[1]))[*5];
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_drive_nonzero: assert property (drv_ok)
		else $error("drive strength field is zero");
	a_caps_follow: assert property (load_cap_en == crystal_osc_en)
		else $error("load caps differ from crystal mode");
	a_unlock_low: assert property (s_unlock_on |=> !pll_unlocked_pin_n)
		else $error("unlock pin not low");
	a_unlock_high: assert property (s_unlock_off |=> pll_unlocked_pin_n)
		else $error("unlock pin not high");
	a_gate_blocks: assert property (output_gate_pin_n[*8] |-> (driver_en & ~$past(driver_en)) == '0)
		else $error("output started while gate pin high");
	a_irq_release: assert property ($rose(irq_pin_n) |-> $past(bus_wr, 2) || $past(bus_wr, 3) || $past(bus_wr, 4))
		else $error("interrupt released without a write");
	a_idle_level: assert property (s_idle_off |-> $stable(clock_true_pin[0]) && $stable(clock_complement_pin[0]))
		else $error("disabled output pins moved");
endmodule // csf_checker

bind csf_clock_ctrl csf_checker u_csf_checker
(
	.hclk, .hresetn, .hsel, .htrans, .hwrite, .hreadyout, .hresp, .output_gate_pin_n,
	.pll_unlocked_status, .crystal_osc_en, .load_cap_en, .pll_unlocked_pin_n, .irq_pin_n,
	.clock_true_pin, .clock_complement_pin, .driver_en, .single_ended_drive_strength
);

// ==== test_clock_source_fault_output_ctrl.sv ====
`timescale 1ns/1ps
module test_clock_source_fault_output_ctrl;
	logic hclk, hresetn, hwrite, hreadyout, hresp, output_gate_pin_n;
	logic [31:0] haddr, hwdata, hrdata, rdat;
	logic [1:0] htrans, ref_sel_pins, active_ref_sel;
	logic [3:0] input_absent_status, synth_tick, clock_true_pin, clock_complement_pin, driver_en;
	logic feedback_absent_status, pll_unlocked_status, crystal_osc_en, load_cap_en;
	logic external_feedback_sel, pll_unlocked_pin_n, irq_pin_n;
	logic [7:0] single_ended_drive_strength;
	int num_errors = 0;
	int checked = 0;
	int n;
	csf_clock_ctrl u_csf_clock_ctrl (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ref_sel_pins,
		.output_gate_pin_n, .input_absent_status, .feedback_absent_status, .pll_unlocked_status,
		.synth_tick, .active_ref_sel, .crystal_osc_en, .load_cap_en, .external_feedback_sel,
		.pll_unlocked_pin_n, .irq_pin_n, .clock_true_pin, .clock_complement_pin, .driver_en,
		.single_ended_drive_strength);
	csf_synth_model u_csf_synth_model (.hclk, .hresetn, .synth_tick);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic stop_test;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic wc(input int k);
		repeat (k) @(posedge hclk);
	endtask
	task automatic rdy;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= 1'b0;
		rdy();
		htrans <= 2'h0;
		rdy();
		rdat = hrdata;
		chk(rdat, exp);
	endtask
	// half period of output 0 in cycles
	task automatic gap;
		logic p;
		p = clock_true_pin[0];
		n = 0;
		while (clock_true_pin[0] === p && n < 400)
		begin
			@(posedge hclk);
			n++;
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rc(csf_pkg::OFS_CTRL, 32'(csf_pkg::CTRL_RST));
		rc(csf_pkg::OFS_MASK, 32'(csf_pkg::MASK_RST));
		rc(csf_pkg::OFS_OUT_EN, 32'(csf_pkg::OUT_EN_RST));
		rc(csf_pkg::OFS_OUT_CFG, {4{csf_pkg::CFG_RST}});
		rc(csf_pkg::OFS_DIV0, 32'(csf_pkg::DIV_RST));
		rc(8'h1c, 32'h0);
		chk(32'(single_ended_drive_strength), 32'hff);
		$display("reset test done");
	endtask
	task automatic t_select;
		for (int s = 0; s < 4; s++)
		begin
			wr(csf_pkg::OFS_CTRL, 32'(s << 1) | 32'h10);
			wc(2);
			chk(32'(active_ref_sel), 32'(s));
			chk(32'({crystal_osc_en, load_cap_en, external_feedback_sel}), 32'h1);
			ref_sel_pins <= 2'(3 - s);
			wr(csf_pkg::OFS_CTRL, 32'h9);
			wc(8);
			chk(32'(active_ref_sel), 32'(3 - s));
		end
		$display("select test done");
	endtask
	task automatic t_status;
		input_absent_status <= 4'ha;
		feedback_absent_status <= 1'b1;
		pll_unlocked_status <= 1'b1;
		wc(10);
		rc(csf_pkg::OFS_STATUS, 32'h3a);
		chk(32'({pll_unlocked_pin_n, irq_pin_n}), 32'h0);
		input_absent_status <= 4'h0;
		feedback_absent_status <= 1'b0;
		pll_unlocked_status <= 1'b0;
		wc(10);
		rc(csf_pkg::OFS_STICKY, 32'h3a);
		wr(csf_pkg::OFS_STICKY, 32'h3f);
		rc(csf_pkg::OFS_STICKY, 32'h3a);
		wr(csf_pkg::OFS_STICKY, 32'h0);
		wc(3);
		rc(csf_pkg::OFS_STICKY, 32'h0);
		chk(32'(irq_pin_n), 32'h1);
		wr(csf_pkg::OFS_MASK, 32'h1);
		input_absent_status <= 4'h1;
		wc(10);
		rc(csf_pkg::OFS_STICKY, 32'h1);
		chk(32'(irq_pin_n), 32'h1);
		wr(csf_pkg::OFS_MASK, 32'h0);
		wc(3);
		chk(32'(irq_pin_n), 32'h0);
		input_absent_status <= 4'h0;
		wc(8);
		wr(csf_pkg::OFS_STICKY, 32'h0);
		wc(3);
		chk(32'(irq_pin_n), 32'h1);
		$display("status test done");
	endtask
	task automatic t_out;
		wr(csf_pkg::OFS_OUT_EN, 32'h1);
		wr(csf_pkg::OFS_DIV0, 32'h7);
		rc(csf_pkg::OFS_DIV0, 32'h6);
		output_gate_pin_n <= 1'b0;
		wc(8);
		chk(32'(driver_en), 32'h1);
		rc(csf_pkg::OFS_ACTIVE, 32'h4);
		gap();
		gap();
		chk(32'(n), 32'h6);
		chk(32'(clock_true_pin[0] ^ clock_complement_pin[0]), 32'h1);
		wr(csf_pkg::OFS_OUT_CFG, 32'hc1);
		// switch may wait up to two toggles, then one partial half
		repeat (5) gap();
		chk(32'(n), 32'h9);
		wr(csf_pkg::OFS_DIV0, 32'h0);
		rc(csf_pkg::OFS_DIV0, 32'h2);
		repeat (4) gap();
		chk(32'(n), 32'h3);
		for (int d = 1; d < 4; d++)
		begin
			wr(csf_pkg::OFS_OUT_CFG, {24'h0, 2'(d), 6'h31});
			wc(2);
			chk(32'(single_ended_drive_strength[1:0]), 32'(d));
		end
		gap();
		chk(32'(clock_true_pin[0] ^ clock_complement_pin[0]), 32'h0);
		$display("output test done");
	endtask
	task automatic t_disable;
		wr(csf_pkg::OFS_OUT_CFG, 32'hc0);
		wr(csf_pkg::OFS_DIV0, 32'd40);
		repeat (3) gap();
		if (clock_true_pin[0] === 1'b0)
			gap();
		wr(csf_pkg::OFS_OUT_EN, 32'h0);
		wc(20);
		chk(32'(driver_en[0]), 32'h1);
		wc(40);
		chk(32'({driver_en[0], clock_true_pin[0], clock_complement_pin[0]}), 32'h1);
		wr(csf_pkg::OFS_OUT_CFG, 32'hcc);
		wr(csf_pkg::OFS_OUT_EN, 32'h1);
		wc(30);
		wr(csf_pkg::OFS_OUT_EN, 32'h0);
		wc(3);
		chk(32'({driver_en[0], clock_true_pin[0], clock_complement_pin[0]}), 32'h2);
		wr(csf_pkg::OFS_OUT_EN, 32'h1);
		wc(4);
		chk(32'(driver_en[0]), 32'h1);
		output_gate_pin_n <= 1'b1;
		wc(8);
		chk(32'(driver_en), 32'h0);
		$display("disable test done");
	endtask
	// ----------------------------------------
	// clock, stimulus, watchdog
	// ----------------------------------------
	initial
	begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	initial
	begin
		{hresetn, hwrite, feedback_absent_status, pll_unlocked_status} = '0;
		{haddr, hwdata, htrans, input_absent_status} = '0;
		ref_sel_pins = 2'h3;
		output_gate_pin_n = 1'b1;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		wc(10);
		t_reset();
		t_select();
		t_status();
		t_out();
		t_disable();
		stop_test();
	end
	initial
	begin
		wc(20000);
		num_errors++;
		stop_test();
	end
endmodule // test_clock_source_fault_output_ctrl
